// ---- hw/spt_pkg.sv ----
// What this block does
// - Idle delay setting, 0 to 0xff character times, writable and readable.
// - Idle delay resets to 3 character times.
// - Send buffered bytes after one or more bytes and idle delay elapsed.
// - Send immediately once the buffer holds 100 bytes.
// - Idle delay of zero sends each byte as it arrives.
package spt_pkg;
    localparam int SPT_MAX_PKT = 100;
    localparam logic [7:0] SPT_DELAY_RST = 8'h03;
    localparam int SPT_CNT_W = 7;
    localparam int SPT_BAUD_DEF = 115200;
    localparam int SPT_CLK_HZ = 100000000;
    localparam int SPT_CLK_PER_BIT = SPT_CLK_HZ / SPT_BAUD_DEF;
    localparam int SPT_BIT_W = 16;
    localparam int SPT_BITS_NOPAR = 10;
    localparam int SPT_BITS_PAR = 11;
    typedef enum logic [2:0] {
        SPT_FILL = 3'b001,
        SPT_SEND = 3'b010,
        SPT_WAIT = 3'b100
    } spt_state_e;
endpackage

// ---- hw/spt_char_if.sv ----
`timescale 1ns/1ps
interface spt_char_if;
    logic char_tick;
    logic restart;
    modport timer (input restart, output char_tick);
    modport user (output restart, input char_tick);
endinterface

// ---- hw/spt_char_timer.sv ----
`timescale 1ns/1ps
module spt_char_timer
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [spt_pkg::SPT_BIT_W-1:0] clk_per_bit_in,
    input wire logic parity_on_in,
    spt_char_if.timer ch
);
    import spt_pkg::*;
    logic [SPT_BIT_W+3:0] cnt_reg, cnt_next, period;
    logic tick_next, tick_reg;
    always_comb
    begin
        period = (parity_on_in ? (SPT_BIT_W+4)'(SPT_BITS_PAR) : (SPT_BIT_W+4)'(SPT_BITS_NOPAR))
            * {4'h0, clk_per_bit_in};
        tick_next = 1'b0;
        cnt_next = cnt_reg + 1'b1;
        if (ch.restart)
        begin
            cnt_next = '0;
        end
        else if (cnt_next >= period)
        begin
            cnt_next = '0;
            tick_next = 1'b1;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end
    assign ch.char_tick = tick_reg;
endmodule

// ---- hw/spt_framer.sv ----
`timescale 1ns/1ps
module spt_framer
#(
    parameter int MAX_PKT = spt_pkg::SPT_MAX_PKT
)
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [spt_pkg::SPT_BIT_W-1:0] clk_per_bit_in,
    input wire logic parity_on_in,
    input wire logic delay_we_in,
    input wire logic [7:0] delay_wdata_in,
    output logic [7:0] delay_out,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    output logic rx_ready_out,
    output logic tx_valid_out,
    output logic [7:0] tx_data_out,
    output logic tx_last_out,
    input wire logic tx_ready_in,
    output logic [spt_pkg::SPT_CNT_W-1:0] fill_out
);
    import spt_pkg::*;
    spt_char_if ch();
    spt_char_timer u_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clk_per_bit_in(clk_per_bit_in),
        .parity_on_in(parity_on_in),
        .ch(ch)
    );
    logic [7:0] mem_reg [MAX_PKT];
    logic [7:0] mem_next [MAX_PKT];
    spt_state_e state_reg, state_next;
    logic [SPT_CNT_W-1:0] cnt_reg, cnt_next, rd_reg, rd_next;
    logic [7:0] delay_reg, delay_next, idle_reg, idle_next;
    logic [7:0] dout_reg, dout_next;
    logic take, fire;
    // Bytes are refused while a packet drains; the host side must hold them
    assign rx_ready_out = (state_reg == SPT_FILL) && (cnt_reg < SPT_CNT_W'(MAX_PKT));
    assign take = rx_valid_in && rx_ready_out;
    assign ch.restart = take;
    assign tx_valid_out = (state_reg == SPT_SEND);
    assign tx_last_out = tx_valid_out && (rd_reg == cnt_reg - 1'b1);
    assign tx_data_out = dout_reg;
    assign delay_out = delay_reg;
    assign fill_out = cnt_reg;
    always_comb
    begin
        delay_next = delay_we_in ? delay_wdata_in : delay_reg;
        mem_next = mem_reg;
        cnt_next = cnt_reg;
        rd_next = rd_reg;
        idle_next = idle_reg;
        state_next = state_reg;
        dout_next = dout_reg;
        fire = 1'b0;
        case (state_reg)
            SPT_FILL:
            begin
                if (take)
                begin
                    mem_next[cnt_reg] = rx_data_in;
                    cnt_next = cnt_reg + 1'b1;
                    idle_next = 8'h00;
                    // Zero delay or full buffer sends at once
                    fire = (delay_reg == 8'h00)
                        || (cnt_next == SPT_CNT_W'(MAX_PKT));
                end
                else if (cnt_reg != '0)
                begin
                    // Saturate so a long silence never wraps back below the delay
                    if (ch.char_tick && idle_reg != 8'hff)
                    begin
                        idle_next = idle_reg + 1'b1;
                    end
                    fire = (idle_reg >= delay_reg);
                end
                if (fire)
                begin
                    state_next = SPT_SEND;
                    rd_next = '0;
                    dout_next = take && cnt_reg == '0 ? rx_data_in : mem_reg[0];
                end
            end
            SPT_SEND:
            begin
                if (tx_ready_in)
                begin
                    if (tx_last_out)
                    begin
                        state_next = SPT_WAIT;
                    end
                    else
                    begin
                        rd_next = rd_reg + 1'b1;
                        dout_next = mem_reg[rd_next];
                    end
                end
            end
            SPT_WAIT:
            begin
                cnt_next = '0;
                idle_next = 8'h00;
                state_next = SPT_FILL;
            end
            default:
            begin
                state_next = SPT_FILL;
            end
        endcase
    end
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= SPT_FILL;
            cnt_reg <= '0;
            rd_reg <= '0;
            idle_reg <= 8'h00;
            delay_reg <= SPT_DELAY_RST;
            dout_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            rd_reg <= rd_next;
            idle_reg <= idle_next;
            delay_reg <= delay_next;
            dout_reg <= dout_next;
        end
    end
    always_ff @(posedge clk_in)
    begin
        // No reset: a slot is only read after a byte has been written to it
        mem_reg <= mem_next;
    end

    delay_reset_a: assert property (@(posedge clk_in)
        $rose(nrst_in) |-> delay_out == SPT_DELAY_RST)
        else $error("idle delay not at reset value");
    delay_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        delay_we_in |=> delay_out == $past(delay_wdata_in))
        else $error("idle delay write lost");
    full_send_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take && cnt_reg == SPT_CNT_W'(MAX_PKT-1) |=> tx_valid_out)
        else $error("full buffer not sent");
    zero_send_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take && delay_reg == 8'h00 && cnt_reg == '0
        |=> tx_valid_out && fill_out == SPT_CNT_W'(1))
        else $error("zero delay byte not sent alone");
    no_early_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_reg == SPT_FILL && !take && idle_reg < delay_reg && cnt_reg < SPT_CNT_W'(MAX_PKT)
        |=> !tx_valid_out)
        else $error("packet sent before idle delay");
    idle_send_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_reg == SPT_FILL && !take && cnt_reg != '0 && idle_reg >= delay_reg
        |=> tx_valid_out)
        else $error("idle packet not sent");
    idle_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take |=> idle_reg == 8'h00)
        else $error("idle count not restarted");
    empty_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_reg == SPT_FILL && cnt_reg == '0 && !take |=> !tx_valid_out)
        else $error("empty buffer sent");

    // Drain steps: a byte offered, stalled or taken, the last one ends it, then refill
    sequence byte_stall_s;
        tx_valid_out && !tx_ready_in;
    endsequence
    sequence byte_taken_s;
        tx_valid_out && tx_ready_in;
    endsequence
    sequence last_taken_s;
        tx_valid_out && tx_ready_in && tx_last_out;
    endsequence
    sequence refill_s;
        !tx_valid_out && !rx_ready_out ##1 rx_ready_out && fill_out == '0;
    endsequence
    byte_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        byte_stall_s
        |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
        else $error("stalled packet byte changed");
    byte_order_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        byte_taken_s ##0 !tx_last_out
        |=> tx_valid_out && rd_reg == $past(rd_reg) + 1'b1)
        else $error("packet byte skipped");
    drain_end_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        last_taken_s
        |=> refill_s)
        else $error("buffer not refilled after packet");
    busy_refuse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tx_valid_out
        |-> !rx_ready_out)
        else $error("byte accepted while packet drains");
    full_refuse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        fill_out == SPT_CNT_W'(MAX_PKT)
        |-> !rx_ready_out)
        else $error("byte accepted into full buffer");
    fill_count_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take
        |=> fill_out == $past(fill_out) + 1'b1)
        else $error("taken byte not counted");
    idle_step_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_reg == SPT_FILL && !take && cnt_reg != '0 && ch.char_tick && idle_reg != 8'hff
        |=> idle_reg == $past(idle_reg) + 1'b1)
        else $error("idle count missed a character time");
    idle_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_reg == SPT_FILL && !take && !ch.char_tick
        |=> idle_reg == $past(idle_reg))
        else $error("idle count moved without a character time");
    delay_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !delay_we_in
        |=> $stable(delay_out))
        else $error("idle delay changed without a write");
    first_byte_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_reg == SPT_FILL && !take && cnt_reg != '0 && idle_reg >= delay_reg
        |=> tx_data_out == $past(mem_reg[0]) && rd_reg == '0)
        else $error("idle packet does not start with oldest byte");
    zero_first_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take && cnt_reg == '0 && delay_reg == 8'h00
        |=> tx_data_out == $past(rx_data_in) && tx_last_out)
        else $error("zero delay byte not offered alone");
endmodule

// ---- verif/spt_host_model.sv ----
`timescale 1ns/1ps
module spt_host_model
(
    input wire logic clk_in,
    input wire logic rx_ready_in,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out
);
    initial
    begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'h00;
    end
    // Byte held until taken; once released the data is scrambled so stale values never match
    task automatic send(input logic [7:0] b);
        @(posedge clk_in) #1;
        rx_valid_out = 1'b1;
        rx_data_out = b;
        do @(posedge clk_in); while (rx_ready_in !== 1'b1);
        #1;
        rx_valid_out = 1'b0;
        rx_data_out = ~b;
    endtask
endmodule

// ---- verif/tb_serial_packetization_trigger.sv ----
`timescale 1ns/1ps
module tb_serial_packetization_trigger;
    import spt_pkg::*;
    typedef struct {logic [7:0] dly; int n; int plen; logic par; int cpb;} spt_row_s;
    logic [SPT_BIT_W-1:0] cpb_in;
    logic clk_in, nrst_in, delay_we_in, par_in, rx_valid, rx_ready, tx_valid, tx_last, tx_ready_in;
    logic [7:0] delay_wdata_in, delay_out, rx_data, tx_data;
    logic [SPT_CNT_W-1:0] fill_out;
    int miscompares = 0, check_count = 0, cyc = 0, last_take = 0;
    spt_row_s rows[4] = '{'{8'h03, 4, 4, 1'b0, 2}, '{8'h01, 2, 2, 1'b1, 3},
        '{8'h00, 3, 1, 1'b0, 2}, '{8'hff, 100, 100, 1'b0, 2}};
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    spt_framer dut (.clk_in(clk_in), .nrst_in(nrst_in), .clk_per_bit_in(cpb_in),
        .parity_on_in(par_in), .delay_we_in(delay_we_in), .delay_wdata_in(delay_wdata_in),
        .delay_out(delay_out), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
        .rx_ready_out(rx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
        .tx_last_out(tx_last), .tx_ready_in(tx_ready_in), .fill_out(fill_out));
    spt_host_model host (.clk_in(clk_in), .rx_ready_in(rx_ready), .rx_valid_out(rx_valid),
        .rx_data_out(rx_data));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            last_take <= cyc;
        if (cyc == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic run_row(input spt_row_s r);
        int k = 0;
        int len;
        int gap;
        int dl = int'(r.dly);
        int ch = (r.par ? SPT_BITS_PAR : SPT_BITS_NOPAR) * r.cpb;
        logic done;
        @(posedge clk_in) #1;
        delay_we_in = 1'b1;
        delay_wdata_in = r.dly;
        par_in = r.par;
        cpb_in = SPT_BIT_W'(r.cpb);
        @(posedge clk_in) #1;
        delay_we_in = 1'b0;
        check(delay_out === r.dly, "delay readback");
        fork
            for (int i = 0; i < r.n; i++) host.send(8'(i + 7));
            while (k < r.n)
            begin
                len = 0;
                while (tx_valid !== 1'b1) @(posedge clk_in) #1;
                gap = cyc - last_take;
                check(fill_out === SPT_CNT_W'(r.plen), "packet fill");
                // A full buffer fires on its last byte; otherwise the idle window applies
                check(r.plen == SPT_MAX_PKT ? gap == 1
                    : gap >= dl * ch - 1 && gap <= dl * ch + ch + 4, "idle timing");
                // Radio stalls first; the byte on offer must stand meanwhile
                repeat (2) @(posedge clk_in) #1;
                tx_ready_in = 1'b1;
                do
                begin
                    check(tx_data === 8'(k + 7), "packet byte");
                    check(rx_ready === 1'b0, "byte accepted mid packet");
                    len++;
                    k++;
                    done = tx_last;
                    @(posedge clk_in) #1;
                end while (done !== 1'b1 && tx_valid === 1'b1);
                tx_ready_in = 1'b0;
                check(len == r.plen, "packet length");
            end
        join
        $display("row delay %0d bytes %0d done", r.dly, r.n);
    endtask
    initial
    begin
        nrst_in = 1'b0;
        delay_we_in = 1'b0;
        delay_wdata_in = 8'h00;
        par_in = 1'b0;
        cpb_in = SPT_BIT_W'(2);
        tx_ready_in = 1'b0;
        repeat (5) @(posedge clk_in);
        #1;
        check(delay_out === SPT_DELAY_RST && tx_valid === 1'b0, "reset state");
        nrst_in = 1'b1;
        $display("reset test done");
        foreach (rows[i]) run_row(rows[i]);
        // A byte still buffered when reset hits must be dropped, not sent
        host.send(8'h55);
        check(fill_out === SPT_CNT_W'(1) && tx_valid === 1'b0, "byte buffered");
        nrst_in = 1'b0;
        @(posedge clk_in) #1;
        nrst_in = 1'b1;
        check(delay_out === SPT_DELAY_RST && fill_out === '0 && tx_valid === 1'b0
            && rx_ready === 1'b1, "second reset");
        $display("second reset test done");
        end_of_test();
    end
endmodule
